// File: inc/bwa_pkg.sv
// Purpose: shared constants for the block window access unit
// Assumes: 32-bit Avalon-MM register bus, byte addressed
// Notes: two windows, each a command pair, a status word and an aperture
`default_nettype none
package bwa_pkg;
  localparam int NUM_WIN = 2;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  // byte address map: bit 15 global block, bit 14 window, bit 13 aperture
  localparam int GLB_BIT = 15;
  localparam int WIN_BIT = 14;
  localparam int APT_BIT = 13;
  localparam logic [15:0] WIN_STRIDE = 16'h4000;
  localparam logic [15:0] APT_OFFSET = 16'h2000;
  localparam logic [15:0] GLB_BASE = 16'h8000;
  // register word selects, address bits 4:2
  localparam logic [2:0] REG_CMD_LO = 3'h0;
  localparam logic [2:0] REG_CMD_HI = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_FLAGS = 3'h0;
  localparam logic [2:0] REG_WIN_EN = 3'h1;
  localparam logic [2:0] REG_LOCK_BASE = 3'h2;
  localparam logic [2:0] REG_LOCK_LIMIT = 3'h3;
  // command layout: media line address (byte address >> 6) in bits 36:0
  localparam int LINE_SHIFT = 6;
  localparam int LINE_BYTES = 64;
  localparam int APT_BYTES = 8192;
  localparam int ADDR_BITS = 37;
  localparam int HI_ADDR_W = 5;
  localparam int LEN_W = 8;
  localparam int HI_LEN_LSB = 16;
  localparam int HI_DIR_BIT = 24;
  localparam logic [31:0] HI_MASK = 32'h01FF_001F;
  localparam logic [7:0] MAX_LEN = 8'h80;
  localparam int WORD_IDX_W = 4;
  localparam int APT_LINE_W = 7;
  localparam int CNT_W = 12;
  // media store
  localparam int MEDIA_LINE_W = 8;
  localparam int MEDIA_LINES = 256;
  localparam int MEDIA_WORDS = 4096;
  // status bits
  localparam int ST_INVALID = 0;
  localparam int ST_UE = 1;
  localparam int ST_DIR = 2;
  localparam int ST_LOCKED = 3;
  localparam int ST_OFF = 4;
  localparam int ST_RETRY = 8;
  localparam int ST_PENDING = 31;
  localparam int ERR_W = 5;
  // module flags word
  localparam logic INVAL_REQ = 1'b0;
  localparam logic BUFFERED = 1'b1;
  localparam logic [31:0] LOCK_RESET = 32'h0000_0000;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge
endpackage : bwa_pkg
`default_nettype wire

// File: verif/block_window_access_tb.sv
// Purpose: self-checking bench for the block window access unit
// Assumes: two windows, one wait state on reads, none on writes
// Notes: window 1 carries the error cases, window 0 the good block
`timescale 1ns/10ps
`default_nettype none
module block_window_access_tb;
  import bwa_pkg::*;
  logic clk;
  logic rstN;
  logic mediaFault;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [DATA_W-1:0] writedata;
  logic [3:0] byteenable;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  block_window_access dut_u (.clk(clk), .rst_n(rstN), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .mediaFault(mediaFault));
  bw_host_model hostU (.clk(clk), .readdata(readdata),
    .waitrequest(waitrequest), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    hostU.access(1'b1, a, 32'h0000_0000, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic wr(input logic [15:0] a, input logic [31:0] wd);
    logic [31:0] unused;
    hostU.access(1'b0, a, wd, unused);
  endtask : wr

  task automatic cmd(input logic [15:0] b, input logic [31:0] lo,
                     input logic [31:0] hi);
    wr(b, lo);
    wr(b + 16'h0004, hi);
  endtask : cmd

  function automatic logic [15:0] apt(input logic [15:0] b, input int k);
    return b + APT_OFFSET + 16'(4 * k);
  endfunction : apt

  function automatic logic [31:0] pat(input int k);
    return 32'h5A5A_0000 + 32'(k);
  endfunction : pat

  // error latched, held over repeated reads, cleared by a command write
  task automatic err_case(input logic [31:0] hi, input logic wrAp,
                          input logic [31:0] exp);
    cmd(WIN_STRIDE, 32'h0000_0005, hi);
    if (wrAp) begin
      wr(apt(WIN_STRIDE, 0), pat(0));
    end else begin
      // an uncorrectable error still returns the stored word, flagged
      rd_chk(apt(WIN_STRIDE, 0), exp[ST_UE] ? pat(0) : 32'h0000_0000);
    end
    rd_chk(WIN_STRIDE + 16'h0008, exp);
    rd_chk(WIN_STRIDE + 16'h0008, exp);
    wr(WIN_STRIDE + 16'h0004, hi);
    rd_chk(WIN_STRIDE + 16'h0008, 32'h8000_0000);
  endtask : err_case

  initial begin
    rstN = 1'b0;
    mediaFault = 1'b0;
    repeat (4) @(posedge clk);
    rstN <= 1'b1;
    @(posedge clk);
    rd_chk(16'h0008, 32'h0000_0000);
    rd_chk(GLB_BASE, 32'h0000_0002);
    rd_chk(GLB_BASE + 16'h0004, 32'h0000_0003);
    wr(16'h000C, 32'hFFFF_FFFF);
    rd_chk(16'h000C, 32'h0000_0000);
    cmd(16'h0000, 32'h0000_0005, 32'h0102_0000);
    rd_chk(16'h0000, 32'h0000_0005);
    rd_chk(16'h0004, 32'h0102_0000);
    rd_chk(16'h0008, 32'h8000_0000);
    for (int k = 0; k < 32; k++) wr(apt(16'h0000, k), pat(k));
    rd_chk(16'h0008, 32'h0000_0000);
    wr(apt(16'h0000, 32), 32'hFFFF_FFFF);
    rd_chk(16'h0008, 32'h0000_0000);
    cmd(WIN_STRIDE, 32'h0000_0005, 32'h0002_0000);
    for (int k = 0; k < 32; k++) rd_chk(apt(WIN_STRIDE, k), pat(k));
    rd_chk(apt(WIN_STRIDE, 32), 32'h0000_0000);
    rd_chk(WIN_STRIDE + 16'h0008, 32'h0000_0000);
    cmd(16'h0000, 32'h0000_0006, 32'h0001_0000);
    rd_chk(apt(16'h0000, 0), pat(16));
    err_case(32'h0002_0000, 1'b1, 32'(1) << ST_DIR);
    err_case(32'h0000_0000, 1'b0, 32'(1) << ST_INVALID);
    err_case(32'h0081_0000, 1'b0, 32'(1) << ST_INVALID);
    wr(GLB_BASE + 16'h000C, 32'h0000_0010);
    err_case(32'h0002_0000, 1'b0, 32'(1) << ST_LOCKED);
    wr(GLB_BASE + 16'h000C, 32'h0000_0000);
    mediaFault <= 1'b1;
    err_case(32'h0002_0000, 1'b0, 32'h0000_0102);
    mediaFault <= 1'b0;
    wr(GLB_BASE + 16'h0004, 32'h0000_0001);
    err_case(32'h0002_0000, 1'b0, 32'(1) << ST_OFF);
    rd_chk(apt(16'h0000, 1), pat(17));
    wr(GLB_BASE + 16'h0004, 32'h0000_0003);
    hostU.idle();
    tally_and_finish();
  end
endmodule : block_window_access_tb
`default_nettype wire

// File: verif/bw_host_model.sv
// Purpose: host side bus master for the block window unit
// Assumes: each access is launched just after a rising edge
// Notes: no cache, no write queue; every store reaches the device at once
`timescale 1ns/10ps
`default_nettype none
module bw_host_model
  import bwa_pkg::*;
(
  input wire logic clk,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest,
  output logic [ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [DATA_W-1:0] writedata,
  output logic [3:0] byteenable
);
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'h0;
  end

  // uncached stores need no line flush or invalidation
  // only window accesses exist, never a direct mapping
  // no queue to drain; one caller runs a whole block
  // next access may start on the accept edge, so no release here
  task automatic access(input logic isRd, input logic [ADDR_W-1:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
    address <= a;
    read <= isRd;
    write <= !isRd;
    writedata <= wd;
    byteenable <= 4'hF;
    // waitrequest and readdata seen as they stood before this edge
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
  endtask : access

  task automatic idle();
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : idle
endmodule : bw_host_model
`default_nettype wire

// File: verilog/block_window_access.sv
// Purpose: block window access unit of a persistent memory module
// Assumes: Avalon-MM slave, 32-bit words, one clock, async active-low reset
// Notes: media store is a small on-chip array; faults arrive on a pin
//
// Contract
// RULE1: command register picks media address, direction and length.
// RULE2: each window has an 8k aperture reaching the programmed media data.
// RULE3: status latches transfer errors, cleared by any command write.
// RULE4: length counts 64-byte lines, one unit per aperture line.
// RULE5: one block per command; aperture beyond the length is ignored.
// RULE6: equal numbers of command, status, aperture; windows run independently.
// RULE7: a window takes a new command at once, no recovery time.
// RULE8: host reprograms the command before every single block.
// RULE9: host recomputes aperture addresses at each interleave line.
// RULE10: host invalidates cached aperture lines before reading.
// RULE11: module reports a read-invalidation-required flag.
// RULE12: host writes the aperture non-temporally or flushes lines.
// RULE13: host never mixes window and direct mapping on one region.
// RULE14: host drains write queues of the set on flush or sync.
// RULE15: host drains all write queues before power-off or unload.
// RULE16: host writes a whole block on one processor, unpreempted.
// RULE17: command low 37 bits hold media address in 64-byte lines.
// RULE18: command bit 56 is direction, write one; traffic checked against it.
// RULE19: status flags bad address, uncorrectable, direction, locked or off.
// RULE20: buffered module shows pending until done, retry on failure.
// RULE21: status reads have no effect; errors hold until next command.
`timescale 1ns/10ps
`default_nettype none
module block_window_access
  import bwa_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic mediaFault
);
  logic rdValid;
  logic faultMeta;
  logic faultSync;
  logic [NUM_WIN-1:0] winEnable;
  logic [31:0] lockBase;
  logic [31:0] lockLimit;
  logic [31:0] media [MEDIA_WORDS];

  logic [ADDR_BITS-1:0] cmdAddr [NUM_WIN];
  logic [LEN_W-1:0] cmdLen [NUM_WIN];
  logic [NUM_WIN-1:0] cmdDir;
  logic [31:0] statusWord [NUM_WIN];
  logic [NUM_WIN-1:0] xferW;

  // address decode
  wire isGlb = address[GLB_BIT];
  wire winIdx = address[WIN_BIT];
  wire inApt = !isGlb && address[APT_BIT];
  wire [2:0] regSel = address[4:2];
  wire [10:0] aptWord = address[12:2];
  wire [APT_LINE_W-1:0] aptLine = aptWord[10:WORD_IDX_W];

  // selected window
  wire [ADDR_BITS-1:0] curAddr = cmdAddr[winIdx];
  wire [LEN_W-1:0] curLen = cmdLen[winIdx];
  wire curDir = cmdDir[winIdx];
  wire inRange = {1'b0, aptLine} < curLen; // RULE5 RULE4
  wire [ADDR_BITS:0] mediaLine = {1'b0, curAddr} + 38'(aptLine);
  wire [ADDR_BITS:0] blockEnd = {1'b0, curAddr} + 38'(curLen);
  wire addrBad = (curLen == '0) || (curLen > MAX_LEN)
              || (blockEnd > 38'(MEDIA_LINES)); // RULE19
  wire lockHit = (lockLimit != LOCK_RESET) && (mediaLine >= 38'(lockBase))
              && (mediaLine < 38'(lockLimit)); // RULE19
  wire offHit = !winEnable[winIdx]; // RULE19
  wire dirBad = write != curDir; // RULE18
  wire errAny = addrBad || lockHit || offHit || dirBad;

  // aperture side effects happen on the accepting edge only
  wire rdAccept = read && rdValid;
  wire aptAcc = inApt && (write || rdAccept);
  // a zero-length command has no range, yet must still flag its bad address
  wire aptUsed = aptAcc && (inRange || curLen == '0);
  wire xfer = aptUsed && !errAny;
  wire [ERR_W-1:0] errVec = {offHit, lockHit, dirBad,
                             xfer && faultSync, addrBad};
  wire [ERR_W-1:0] errEv = aptUsed ? errVec : '0;
  wire [11:0] mediaWord = {mediaLine[MEDIA_LINE_W-1:0],
                           aptWord[WORD_IDX_W-1:0]};
  wire mediaWe = xfer && write; // RULE2

  // read data selection
  wire aptData = inRange && !errAny;
  wire [31:0] cmdHiRd = {7'h00, curDir, curLen, 11'h000,
                         curAddr[ADDR_BITS-1:32]};
  wire [31:0] glbRd =
      (regSel == REG_FLAGS) ? {30'h0000_0000, BUFFERED, INVAL_REQ} : // RULE11
      (regSel == REG_WIN_EN) ? 32'(winEnable) :
      (regSel == REG_LOCK_BASE) ? lockBase :
      (regSel == REG_LOCK_LIMIT) ? lockLimit : 32'h0000_0000;
  wire [31:0] winRd =
      (regSel == REG_CMD_LO) ? curAddr[31:0] :
      (regSel == REG_CMD_HI) ? cmdHiRd :
      (regSel == REG_STATUS) ? statusWord[winIdx] : 32'h0000_0000;
  wire [31:0] rdMux = isGlb ? glbRd :
      inApt ? (aptData ? media[mediaWord] : 32'h0000_0000) : winRd; // RULE2

  // reads wait one cycle, writes never wait
  assign waitrequest = read && !rdValid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      readdata <= '0;
    end else begin
      rdValid <= read && !rdValid;
      if (read && !rdValid) readdata <= rdMux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      faultMeta <= 1'b0;
      faultSync <= 1'b0;
    end else begin
      faultMeta <= mediaFault;
      faultSync <= faultMeta;
    end
  end

  wire glbWr = write && isGlb;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      winEnable <= '1;
      lockBase <= LOCK_RESET;
      lockLimit <= LOCK_RESET;
    end else begin
      if (glbWr && regSel == REG_WIN_EN)
        winEnable <= NUM_WIN'(merge(32'(winEnable), writedata, byteenable));
      if (glbWr && regSel == REG_LOCK_BASE)
        lockBase <= merge(lockBase, writedata, byteenable);
      if (glbWr && regSel == REG_LOCK_LIMIT)
        lockLimit <= merge(lockLimit, writedata, byteenable);
    end
  end

  // media storage holds no reset
  always_ff @(posedge clk) begin
    if (mediaWe) media[mediaWord] <= merge(media[mediaWord], writedata,
                                           byteenable);
  end

  // one independent window per index
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi++) begin : g_win
      wire hit = (32'(winIdx) == gi);
      wire regWr = write && !isGlb && !inApt && hit;
      assign xferW[gi] = xfer && hit;
      bw_window u_win ( // RULE6
        .clk(clk),
        .rst_n(rst_n),
        .cmdWrLo(regWr && regSel == REG_CMD_LO),
        .cmdWrHi(regWr && regSel == REG_CMD_HI),
        .wdata(writedata),
        .be(byteenable),
        .xfer(xferW[gi]),
        .errEv(hit ? errEv : '0),
        .cmdAddr(cmdAddr[gi]),
        .cmdLen(cmdLen[gi]),
        .cmdDir(cmdDir[gi]),
        .statusWord(statusWord[gi])
      );
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence aptReadOut;
    read && !rdValid && inApt && !inRange;
  endsequence
  sequence flagsRead;
    read && !rdValid && isGlb && regSel == REG_FLAGS;
  endsequence
  sequence dirMiss;
    aptUsed && dirBad;
  endsequence

  read_wait_a: assert property (read && waitrequest // RULE7
    |=> !waitrequest) else $error("read not answered in one cycle");
  write_nowait_a: assert property (write |-> !waitrequest) // RULE7
    else $error("write stalled");
  unused_space_a: assert property (aptReadOut |=> readdata == '0) // RULE5
    else $error("unused aperture space returned data");
  inval_flag_a: assert property (flagsRead |=> readdata[0] == INVAL_REQ)
    else $error("invalidation flag misreported"); // RULE11
  dir_error_a: assert property (dirMiss // RULE18
    |=> statusWord[$past(winIdx)][ST_DIR])
    else $error("direction error not latched");
  off_window_a: assert property (aptUsed && offHit // RULE19
    |-> !xfer ##1 statusWord[$past(winIdx)][ST_OFF])
    else $error("disabled window moved data");
  no_write_out_a: assert property (aptAcc && !inRange |-> !mediaWe) // RULE5
    else $error("write beyond the block reached media");
  window_only_a: assert property (xfer |-> $onehot(xferW)) // RULE6
    else $error("transfer touched more than one window");
endmodule : block_window_access
`default_nettype wire

// File: verilog/bw_window.sv
// Purpose: command and status state of one block window
// Assumes: error events and transfer strobes come decoded from the bus side
// Notes: any command word write restarts the window
`timescale 1ns/10ps
`default_nettype none
module bw_window
  import bwa_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdWrLo,
  input wire logic cmdWrHi,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  input wire logic xfer,
  input wire logic [ERR_W-1:0] errEv,
  output logic [ADDR_BITS-1:0] cmdAddr,
  output logic [LEN_W-1:0] cmdLen,
  output logic cmdDir,
  output logic [31:0] statusWord
);
  logic [31:0] cmdLo;
  logic [31:0] cmdHi;
  logic [ERR_W-1:0] errFlags;
  logic retry;
  logic pending;
  logic [CNT_W-1:0] xferCnt;

  wire cmdWr = cmdWrLo | cmdWrHi;
  wire [CNT_W-1:0] wordsDue = {cmdLen, {WORD_IDX_W{1'b0}}};
  wire lastWord = xfer && (xferCnt + 12'h001 == wordsDue);
  wire [ERR_W-1:0] next_errFlags = (cmdWr ? '0 : errFlags) | errEv;
  wire next_retry = (retry & ~cmdWr) | (BUFFERED & errEv[ST_UE]);
  wire next_pending = cmdWr ? BUFFERED
                            : (pending & ~lastWord & ~(|errEv));

  assign cmdAddr = {cmdHi[HI_ADDR_W-1:0], cmdLo}; // RULE17
  assign cmdLen = cmdHi[HI_LEN_LSB +: LEN_W]; // RULE4
  assign cmdDir = cmdHi[HI_DIR_BIT]; // RULE18
  // reads of this word have no side effect
  assign statusWord = {pending, 22'h00_0000, retry, 3'h0, errFlags}; // RULE21

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdLo <= '0;
      cmdHi <= '0;
    end else begin
      if (cmdWrLo) cmdLo <= merge(cmdLo, wdata, be); // RULE1
      if (cmdWrHi) cmdHi <= merge(cmdHi, wdata, be) & HI_MASK; // RULE1
    end
  end

  // an event in the clearing cycle still lands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errFlags <= '0;
      retry <= 1'b0;
      pending <= 1'b0;
      xferCnt <= '0;
    end else begin
      errFlags <= next_errFlags; // RULE3 RULE19
      retry <= next_retry; // RULE20
      pending <= next_pending; // RULE20
      xferCnt <= cmdWr ? '0 : (xfer ? xferCnt + 12'h001 : xferCnt); // RULE7
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  clear_on_cmd_a: assert property (cmdWr |=> statusWord[ERR_W-1:0] == '0 // RULE3
    && !retry) else $error("status not cleared by command write");
  hold_errors_a: assert property (!cmdWr && errEv == '0 // RULE21
    |=> $stable(errFlags)) else $error("error bits changed with no cause");
  pending_set_a: assert property (cmdWrHi |=> pending == BUFFERED) // RULE20
    else $error("pending not raised by command");
  pending_done_a: assert property (pending && lastWord && !cmdWr |=> !pending)
    else $error("pending outlived the last line"); // RULE20
endmodule : bw_window
`default_nettype wire
